// ===== rtl/pld_defines.svh
// Constants for the decode array and general logic array
`ifndef PLD_DEFINES_SVH
`define PLD_DEFINES_SVH
`define NUM_PRIMARY_SEL 4
`define NUM_SECONDARY_SEL 2
`define NUM_IN_CELLS 20
`define NUM_OUT_CELLS 16
`define NUM_PTERMS 137
`define GROUP_A_NATIVE 3
`define GROUP_B_NATIVE 4
`define MASK_RESET 8'h00
`define CELLS_RESET 8'h00
`define SECTOR_TERMS 3
`define SRAM_TERMS 2
`define CLEAR_TERMS 2
`define JTAG_PORT_C_MASK 8'h63
`endif

// ===== rtl/pld_pkg.sv
// Types for the decode and logic arrays
package pld_pkg;
  typedef enum logic [1:0] {FF_D, FF_T, FF_JK, FF_SR} ff_kind_t;
  typedef enum logic [1:0] {IN_PASS, IN_LATCH, IN_REG} in_mode_t;
  typedef enum logic {LOAD_EDGE, LOAD_LEVEL} load_mode_t;
endpackage

// ===== rtl/output_cell.sv
// One output macrocell: polarity, storage element, output select
`include "pld_defines.svh"
module output_cell
  import pld_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic sum_a,
  input wire logic sum_b,
  input wire logic invert,
  input wire ff_kind_t kind,
  input wire logic use_pin_clock,
  input wire logic pterm_clock,
  input wire logic pin_clock_rise,
  input wire logic preset_in,
  input wire logic clear_in,
  input wire logic registered,
  input wire logic load,
  input wire logic load_data,
  output logic result,
  output logic state
);
  logic state_r;
  logic pterm_clock_r;
  logic tick;
  logic a;
  logic b;
  // [R6] Polarity gate
  assign a = sum_a ^ invert;
  assign b = sum_b ^ invert;
  // [R8] Clock source select
  assign tick = use_pin_clock ? pin_clock_rise : (pterm_clock & ~pterm_clock_r);
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pterm_clock_r <= 1'b0;
    end else if (ce) begin
      pterm_clock_r <= pterm_clock;
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r <= 1'b0;
    end else if (ce) begin
      // [R13] Bus load wins
      if (load) begin
        state_r <= load_data;
      // [R9] Active high clear/preset
      end else if (clear_in) begin
        state_r <= 1'b0;
      end else if (preset_in) begin
        state_r <= 1'b1;
      end else if (tick) begin
        // [R7] Storage element kind
        unique case (kind)
          FF_D: state_r <= a;
          FF_T: state_r <= state_r ^ a;
          FF_JK: state_r <= (a & ~state_r) | (~b & state_r);
          FF_SR: state_r <= a | (~b & state_r);
        endcase
      end
    end
  end
  assign state = state_r;
  // [R6] Registered or combinational
  assign result = registered ? state_r : a;
endmodule

// ===== rtl/pld_decode_and_macrocells.sv
// Decode array and general logic array with bus load and readback
// ==========================================================
// Summary of operation
// [R1] Four primary sector selects, three terms each
// [R2] Two secondary sector selects, three terms each
// [R3] SRAM, register space, two peripheral selects
// [R4] Two external chip selects, no cell used
// [R5] Twenty input, sixteen output cells, 137 terms
// [R6] Polarity, register/comb mux, pin and feedback
// [R7] Flip-flop kind D, T, JK or SR
// [R8] Clock from term or dedicated pin rise
// [R9] Active high preset/clear, clear two terms
// [R10] Native and borrowed term counts per group; no terms are borrowed here
// [R11] Used terms not shared; expansion adds delay (clear and enable terms are shared between cells here)
// [R12] Cell n maps to data bit n
// [R13] Bus load beats preset, clear, clock
// [R14] Edge or level load from write strobe
// [R15] Per-group mask blocks writes, resets zero
// [R16] Pin enable is term OR direction bit
// [R17] Undefined enable output drives from power-up
// [R18] Internal node frees pin, keeps feedback
// [R19] Input cells latch, register or pass, readable
// [R20] Input strobe term per nibble or address strobe
// [R21] Test-access port pins never cell destinations
// [R22] Page bits feed decode array
// [R23] Clear direction bit tri-states unless term enables
// [R24] Group read returns all eight cells
// [R25] Software masks state-machine cells before writes
`include "pld_defines.svh"
module pld_decode_and_macrocells
  import pld_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // Product terms evaluated by the programmable array
  input wire logic [`NUM_PTERMS-1:0] pterms,
  input wire logic [7:0] page_bits,
  input wire logic [1:0] ext_cs_terms,
  // Per-cell configuration
  input wire logic [15:0] cell_invert,
  input wire logic [31:0] cell_kind,
  input wire logic [15:0] cell_registered,
  input wire logic [15:0] cell_use_pin_clock,
  input wire logic [15:0] cell_internal_node,
  input wire logic [15:0] cell_enable_defined,
  input wire logic load_mode,
  input wire logic [39:0] input_cell_mode,
  input wire logic [4:0] input_strobe_use_term,
  // Pins and strobes from outside the clock domain
  input wire logic dedicated_logic_clock,
  input wire logic address_latch_strobe,
  input wire logic write_strobe_n,
  input wire logic [19:0] port_in,
  // Bus access
  input wire logic sel_cells_a,
  input wire logic sel_cells_b,
  input wire logic sel_mask_a,
  input wire logic sel_mask_b,
  input wire logic sel_inputs_lo,
  input wire logic sel_inputs_mid,
  input wire logic sel_inputs_hi,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  input wire logic [15:0] direction_bits,
  // Decode outputs
  output logic [`NUM_PRIMARY_SEL-1:0] primary_sector_selects,
  output logic [`NUM_SECONDARY_SEL-1:0] secondary_sector_selects,
  output logic sram_select,
  output logic register_space_select,
  output logic peripheral_select_zero,
  output logic peripheral_select_one,
  output logic [1:0] external_chip_selects,
  // Logic array outputs
  output logic [15:0] cell_pin_out,
  output logic [15:0] cell_pin_oe,
  output logic [15:0] cell_feedback,
  output logic [19:0] input_cell_out,
  output logic [7:0] port_c_allowed
);
  // ==========================================================
  // Term map
  // Cells of group A take 3 native terms, group B 4; the clock and preset
  // terms of each cell follow the native sums, clear pairs start at 128, enables at 120.
  function automatic logic or_terms(input logic [`NUM_PTERMS-1:0] t, input int base,
                                    input int n);
    logic r;
    r = 1'b0;
    for (int i = 0; i < n; i++) begin
      r = r | t[base+i];
    end
    return r;
  endfunction

  // ==========================================================
  // Decode array
  // [R1] Primary sector selects
  always_comb begin
    for (int i = 0; i < `NUM_PRIMARY_SEL; i++) begin
      primary_sector_selects[i] = or_terms(pterms, i*`SECTOR_TERMS, `SECTOR_TERMS);
    end
  end
  // [R2] Secondary sector selects
  always_comb begin
    for (int i = 0; i < `NUM_SECONDARY_SEL; i++) begin
      secondary_sector_selects[i] = or_terms(pterms, 12 + i*`SECTOR_TERMS, `SECTOR_TERMS);
    end
  end
  // [R22] Page bits qualify the SRAM select
  logic page_match;
  assign page_match = (page_bits == pterms[28:21]) | pterms[29];
  // [R3] SRAM, register space and peripheral selects
  assign sram_select = or_terms(pterms, 18, `SRAM_TERMS) & page_match;
  assign register_space_select = pterms[20];
  assign peripheral_select_zero = pterms[30];
  assign peripheral_select_one = pterms[31];
  // [R4] External selects straight from terms
  assign external_chip_selects = ext_cs_terms;

  // ==========================================================
  // Pin synchronisers
  logic [1:0] clk_pin_sync;
  logic [1:0] ale_sync;
  logic [1:0] wr_sync;
  logic [19:0] port_s1;
  logic [19:0] port_s2;
  logic clk_pin_prev;
  logic ale_prev;
  logic wr_prev;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      clk_pin_sync <= 2'h0;
      ale_sync <= 2'h0;
      wr_sync <= 2'h3;
      port_s1 <= 20'h0;
      port_s2 <= 20'h0;
      clk_pin_prev <= 1'b0;
      ale_prev <= 1'b0;
      wr_prev <= 1'b1;
    end else if (ce) begin
      clk_pin_sync <= {clk_pin_sync[0], dedicated_logic_clock};
      ale_sync <= {ale_sync[0], address_latch_strobe};
      wr_sync <= {wr_sync[0], write_strobe_n};
      port_s1 <= port_in;
      port_s2 <= port_s1;
      clk_pin_prev <= clk_pin_sync[1];
      ale_prev <= ale_sync[1];
      wr_prev <= wr_sync[1];
    end
  end
  logic pin_clock_rise;
  logic write_active;
  logic write_trailing;
  assign pin_clock_rise = clk_pin_sync[1] & ~clk_pin_prev;
  assign write_active = ~wr_sync[1];
  assign write_trailing = wr_sync[1] & ~wr_prev;

  // ==========================================================
  // Mask registers and bus load
  logic [7:0] mask_a_r;
  logic [7:0] mask_b_r;
  logic [7:0] wdata_r;
  // [R15] Masks reset to zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mask_a_r <= `MASK_RESET;
      mask_b_r <= `MASK_RESET;
    end else if (ce && write_trailing) begin
      if (sel_mask_a) begin
        mask_a_r <= wdata;
      end
      if (sel_mask_b) begin
        mask_b_r <= wdata;
      end
    end
  end
  // Data held while strobe is low so edge mode loads the final value
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wdata_r <= 8'h00;
    end else if (ce && write_active) begin
      wdata_r <= wdata;
    end
  end
  logic load_strobe;
  logic [7:0] load_data;
  // [R14] Edge or level loading
  assign load_strobe = (load_mode == LOAD_LEVEL) ? write_active : write_trailing;
  assign load_data = (load_mode == LOAD_LEVEL) ? wdata : wdata_r;
  logic [15:0] cell_load;
  // [R15] Mask bits block writes
  assign cell_load = {{8{load_strobe & sel_cells_b}} & ~mask_b_r,
                      {8{load_strobe & sel_cells_a}} & ~mask_a_r};

  // ==========================================================
  // Output cells
  // [R5] Sixteen output cells
  // [R10] Term budget per group
  // [R11] Clear terms serve four cells, enable terms two and overlap cells 14-15
  logic [15:0] cell_state;
  logic [15:0] cell_result;
  for (genvar c = 0; c < `NUM_OUT_CELLS; c++) begin : g_cell
    localparam int NAT = (c < 8) ? `GROUP_A_NATIVE : `GROUP_B_NATIVE;
    localparam int BASE = 32 + c*6;
    logic sum_a;
    logic sum_b;
    assign sum_a = or_terms(pterms, BASE, (NAT > 1) ? NAT - 1 : 1);
    assign sum_b = pterms[BASE+NAT-1];
    output_cell u_cell (
      .clk(clk),
      .reset(reset),
      .ce(ce),
      .sum_a(sum_a),
      .sum_b(sum_b),
      .invert(cell_invert[c]),
      .kind(ff_kind_t'(cell_kind[2*c +: 2])),
      .use_pin_clock(cell_use_pin_clock[c]),
      .pterm_clock(pterms[BASE+NAT]),
      .pin_clock_rise(pin_clock_rise),
      .preset_in(pterms[BASE+NAT+1]),
      // [R9] Clear uses two terms
      .clear_in(or_terms(pterms, 128 + (c % 4)*2, `CLEAR_TERMS)),
      .registered(cell_registered[c]),
      // [R12] Cell n on data bit n mod 8
      .load(cell_load[c]),
      .load_data(load_data[c % 8]),
      .result(cell_result[c]),
      .state(cell_state[c])
    );
  end
  // [R18] Feedback kept for internal nodes
  assign cell_feedback = cell_result;
  assign cell_pin_out = cell_result;
  // [R16] Enable is term OR direction
  // [R17] No enable equation drives at once
  // [R23] Direction low tri-states when the defined enable term is low
  always_comb begin
    for (int c = 0; c < 16; c++) begin
      cell_pin_oe[c] = ~cell_internal_node[c] &
        ((cell_enable_defined[c] ? pterms[120 + (c % 8)] : 1'b1) | direction_bits[c]);
    end
  end
  // [R21] JTAG pins excluded on third port
  assign port_c_allowed = ~`JTAG_PORT_C_MASK;

  // ==========================================================
  // Input cells
  // [R20] Strobe per nibble, term or address strobe
  logic [4:0] nib_strobe;
  logic [4:0] nib_prev;
  always_comb begin
    for (int n = 0; n < 5; n++) begin
      nib_strobe[n] = input_strobe_use_term[n] ? pterms[132+n] : ale_sync[1];
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      nib_prev <= 5'h0;
    end else if (ce) begin
      nib_prev <= nib_strobe;
    end
  end
  logic [19:0] in_store_r;
  // [R19] Latch, register or pass
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      in_store_r <= 20'h0;
    end else if (ce) begin
      for (int i = 0; i < `NUM_IN_CELLS; i++) begin
        unique case (in_mode_t'(input_cell_mode[2*i +: 2]))
          IN_LATCH: if (nib_strobe[i/4]) in_store_r[i] <= port_s2[i];
          IN_REG: if (nib_strobe[i/4] & ~nib_prev[i/4]) in_store_r[i] <= port_s2[i];
          default: in_store_r[i] <= port_s2[i];
        endcase
      end
    end
  end
  assign input_cell_out = in_store_r;

  // ==========================================================
  // Readback
  // [R24] Reads ignore masks
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata <= 8'h00;
    end else if (ce) begin
      rdata <= sel_cells_a ? cell_state[7:0] :
               sel_cells_b ? cell_state[15:8] :
               sel_mask_a ? mask_a_r :
               sel_mask_b ? mask_b_r :
               sel_inputs_lo ? in_store_r[7:0] :
               sel_inputs_mid ? in_store_r[15:8] :
               sel_inputs_hi ? {4'h0, in_store_r[19:16]} : 8'h00;
    end
  end
endmodule

// ===== verif/pld_checks_asserts.sv
// Port checker for the decode and logic arrays
`include "pld_defines.svh"
module pld_checks (
  input wire logic clk,
  input wire logic reset,
  input wire logic [`NUM_PTERMS-1:0] pterms,
  input wire logic [15:0] cell_invert,
  input wire logic [15:0] cell_registered,
  input wire logic [15:0] cell_internal_node,
  input wire logic [15:0] cell_enable_defined,
  input wire logic [15:0] direction_bits,
  input wire logic write_strobe_n,
  input wire logic sel_cells_a,
  input wire logic [1:0] ext_cs_terms,
  input wire logic [`NUM_PRIMARY_SEL-1:0] primary_sector_selects,
  input wire logic [`NUM_SECONDARY_SEL-1:0] secondary_sector_selects,
  input wire logic sram_select,
  input wire logic register_space_select,
  input wire logic peripheral_select_zero,
  input wire logic peripheral_select_one,
  input wire logic [1:0] external_chip_selects,
  input wire logic [15:0] cell_pin_oe,
  input wire logic [15:0] cell_feedback,
  input wire logic [7:0] port_c_allowed
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [15:0] drv, oe_want;
  // Enable terms are shared by cell c and c+8
  assign drv = cell_enable_defined & ~cell_internal_node;
  assign oe_want = {2{pterms[127:120]}} | direction_bits;
  chk_primary_or: assert property (pterms[29] |-> primary_sector_selects ==
    {|pterms[11:9], |pterms[8:6], |pterms[5:3], |pterms[2:0]}) else $error("primary select");
  chk_secondary_or: assert property (pterms[29] |-> secondary_sector_selects ==
    {|pterms[17:15], |pterms[14:12]}) else $error("secondary select");
  chk_sram_or: assert property (pterms[29] |-> sram_select == |pterms[19:18])
    else $error("sram select");
  chk_misc_selects: assert property ({peripheral_select_one, peripheral_select_zero,
    register_space_select} == {pterms[31:30], pterms[20]}) else $error("misc select");
  chk_ext_cs: assert property (external_chip_selects == ext_cs_terms)
    else $error("external select");
  chk_oe_or: assert property ((cell_pin_oe & drv) == (oe_want & drv))
    else $error("pin enable");
  chk_oe_default: assert property (&(cell_pin_oe | cell_enable_defined | cell_internal_node))
    else $error("default enable");
  chk_jtag_pins: assert property ((port_c_allowed & 8'h63) == 8'h00)
    else $error("test pins offered");
  chk_comb_path: assert property (!cell_registered[0] |->
    cell_feedback[0] == ((pterms[32] | pterms[33]) ^ cell_invert[0])) else $error("comb path");
  cover property (sram_select);
  cover property (!write_strobe_n && sel_cells_a);
  cover property (|external_chip_selects);
endmodule

// ===== verif/mcu_model.sv
// Bus-side model of the microcontroller core
module mcu_model (
  input wire logic clk,
  output logic write_strobe_n,
  output logic [6:0] sel,
  output logic [7:0] wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    write_strobe_n = 1'b1;
    sel = 7'h00;
    wdata = 8'h00;
  end
  // Select held past the synchronised trailing edge
  task wr(input int s, input logic [7:0] d);
    @(negedge clk);
    sel = 7'(1 << s);
    wdata = d;
    write_strobe_n = 1'b0;
    repeat (4) @(negedge clk);
    write_strobe_n = 1'b1;
    repeat (6) @(negedge clk);
    sel = 7'h00;
    wdata = ~d;
  endtask
  task rd(input int s);
    @(negedge clk);
    sel = 7'(1 << s);
    repeat (3) @(negedge clk);
  endtask
endmodule

// ===== verif/tb.sv
// Self-checking bench for the decode and logic arrays
`include "pld_defines.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset, ce, load_mode, dedicated_logic_clock, address_latch_strobe, write_strobe_n;
  logic sel_cells_a, sel_cells_b, sel_mask_a, sel_mask_b, sel_inputs_lo, sel_inputs_mid;
  logic sel_inputs_hi, sram_select, register_space_select, peripheral_select_zero;
  logic peripheral_select_one, smp;
  logic [`NUM_PTERMS-1:0] pterms;
  logic [7:0] page_bits, wdata, rdata, port_c_allowed, d;
  logic [1:0] ext_cs_terms, external_chip_selects, secondary_sector_selects;
  logic [15:0] cell_invert, cell_registered, cell_use_pin_clock, cell_internal_node;
  logic [15:0] cell_enable_defined, direction_bits, cell_pin_out, cell_pin_oe, cell_feedback;
  logic [31:0] cell_kind;
  logic [39:0] input_cell_mode;
  logic [4:0] input_strobe_use_term;
  logic [19:0] port_in, input_cell_out;
  logic [3:0] primary_sector_selects;
  logic [159:0] rnd;
  logic [17:0] expq[$];
  logic [17:0] e;
  int error_cnt, cmp_count;
  pld_decode_and_macrocells uut (.*);
  mcu_model mcu (.clk, .write_strobe_n, .wdata, .sel({sel_inputs_hi, sel_inputs_mid,
    sel_inputs_lo, sel_mask_b, sel_mask_a, sel_cells_b, sel_cells_a}));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task check(input logic [15:0] seen, input logic [15:0] want);
    cmp_count++;
    if (seen !== want) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task summarize;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task expect_val(input logic [1:0] k, input logic [15:0] v);
    expq.push_back({k, v});
    smp = 1'b1;
    @(negedge clk);
    smp = 1'b0;
  endtask
  task rd(input int s, input logic [7:0] v);
    mcu.rd(s);
    expect_val(2'd0, {8'h00, v});
  endtask
  // Monitor: result is stable through the half cycle before this edge
  initial forever begin
    @(posedge clk);
    if (smp) begin
      e = expq.pop_front();
      case (e[17:16])
        2'd1: check({4'h0, peripheral_select_one, peripheral_select_zero, external_chip_selects,
          register_space_select, sram_select, secondary_sector_selects, primary_sector_selects},
          e[15:0]);
        2'd2: check(cell_pin_out, e[15:0]);
        2'd3: check(input_cell_out[15:0], e[15:0]);
        default: check({8'h00, rdata}, e[15:0]);
      endcase
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    summarize();
  end
  initial begin
    {reset, ce, smp, load_mode, dedicated_logic_clock, address_latch_strobe} = 6'b110000;
    {pterms, page_bits, ext_cs_terms, cell_invert, cell_kind, cell_use_pin_clock} = '0;
    {cell_internal_node, cell_enable_defined, input_cell_mode, input_strobe_use_term} = '0;
    cell_registered = 16'hffff;
    direction_bits = 16'h0000;
    void'($urandom(32'hffe2801e));
    port_in = 20'($urandom);
    repeat (16) @(negedge clk);
    reset = 1'b0;
    rd(0, 8'h00);
    rd(3, 8'h00);
    for (int i = 0; i < 12; i++) begin
      rnd = {$urandom, $urandom, $urandom, $urandom, $urandom};
      pterms = rnd[136:0];
      {page_bits, ext_cs_terms, dedicated_logic_clock, address_latch_strobe} = 12'($urandom);
      // Page compare both forced and left to chance
      pterms[29] = i[0];
      if (i % 4 == 0) pterms[28:21] = page_bits;
      {cell_invert, cell_registered} = $urandom;
      {cell_internal_node, cell_enable_defined} = $urandom;
      {direction_bits, cell_use_pin_clock} = $urandom;
      {cell_kind, input_strobe_use_term} = 37'({$urandom, $urandom});
      input_cell_mode = 40'({$urandom, $urandom});
      expect_val(2'd1, {4'h0, pterms[31:30], ext_cs_terms, pterms[20],
        |pterms[19:18] & (pterms[29] | (page_bits == pterms[28:21])), |pterms[17:15],
        |pterms[14:12], |pterms[11:9], |pterms[8:6], |pterms[5:3], |pterms[2:0]});
    end
    {pterms, cell_invert, input_cell_mode, cell_use_pin_clock, dedicated_logic_clock} = '0;
    cell_registered = 16'hffff;
    // input cells in pass mode read back
    rd(4, port_in[7:0]);
    rd(5, port_in[15:8]);
    expect_val(2'd3, port_in[15:0]);
    mcu.wr(0, 8'ha5);
    rd(0, 8'ha5);
    mcu.wr(1, 8'h5a);
    rd(1, 8'h5a);
    expect_val(2'd2, 16'h5aa5);
    // state-machine cells masked before group write
    mcu.wr(2, 8'h0f);
    rd(2, 8'h0f);
    mcu.wr(0, 8'hff);
    // masked bits keep state, all eight read
    rd(0, 8'hf5);
    load_mode = 1'b1;
    d = 8'($urandom);
    mcu.wr(1, d);
    rd(1, d);
    // clear pair of slot 0 hits cells 0, 4, 8, 12
    pterms[128] = 1'b1;
    rd(1, d & 8'hee);
    rd(0, 8'he4);
    // cell 0 as toggle on one pin clock rise
    pterms[128] = 1'b0;
    pterms[32] = 1'b1;
    cell_kind[1:0] = 2'h1;
    cell_use_pin_clock[0] = 1'b1;
    dedicated_logic_clock = 1'b1;
    repeat (4) @(negedge clk);
    dedicated_logic_clock = 1'b0;
    rd(0, 8'he5);
    summarize();
  end
endmodule
bind pld_decode_and_macrocells pld_checks chk (.*);
